/* include/output_format_offset_cfg.svh */
// Purpose: constants for the output format and offset register bank
// Assumes: AXI4-Lite slave, word index times four is the byte address
// Notes: register bit positions, word offsets and register reset values live here; format_out reset is set in the core
//
// Functional notes
// - format bit 10 low: one word on each rising and falling clock edge
// - format bit 10 high: one word per clock, edge chosen by bit 8
// - bit 9 picks swing: one is 710 mV, zero is 510 mV
// - under register control bit 9 replaces the swing pin
// - single rate with bit 8 high: data change on rising clock edge
// - single rate with bit 8 low: data change on falling clock edge
// - under register control bit 8 replaces the edge pin in single rate
// - double rate with bit 8 high: non-demultiplexed output
// - double rate with bit 8 low: one-to-two demultiplexed output
// - double rate non-demux always keeps clock at zero degree phase
// - offset bits 15:8 are magnitude, zero nominal, 0.176 mV per step
// - offset bit 7 is sign: zero positive, one negative
// - magnitude and sign give up to plus or minus 45 mV offset
// - bit 11 clock phase acts only in double rate demux (bit 8 low): one centres clock
`ifndef OUTPUT_FORMAT_OFFSET_CFG_SVH
`define OUTPUT_FORMAT_OFFSET_CFG_SVH
`define CFG_IDX 4'h1
`define OFS_IDX 4'h2
`define STAT_IDX 4'h8
`define CFG_RESET 16'hb2ff
`define OFS_RESET 16'h007f
`define CFG_PHASE_BIT 11
`define CFG_DDR_N_BIT 10
`define CFG_SWING_BIT 9
`define CFG_EDGE_BIT 8
`define CFG_FIXED_MASK 16'hc0ff
`define CFG_FIXED_VAL 16'h80ff
`define OFS_SIGN_BIT 7
`define OFS_MAG_LSB 8
`define OFS_FIXED_MASK 16'h007f
`define OFS_FIXED_VAL 16'h007f
`define OFS_STEP_UV 17'h000b0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* include/output_format_offset_pkg.sv */
// Purpose: types for the output format and offset register bank
// Assumes: nothing beyond the cfg header
// Notes: output mode is one-hot
package output_format_offset_pkg;
  typedef enum logic [3:0] {
    MODE_DDR_DEMUX = 4'h1,
    MODE_DDR_NODEMUX = 4'h2,
    MODE_SDR_RISING = 4'h4,
    MODE_SDR_FALLING = 4'h8
  } output_mode_t;

  typedef struct packed {
    output_mode_t mode;
    logic swing_high;
    logic clock_centred;
  } format_out_t;

  typedef struct packed {
    logic [7:0] magnitude;
    logic negative;
    logic signed [16:0] offset_uv;
  } offset_out_t;
endpackage : output_format_offset_pkg

/* core/output_format_offset_regs.sv */
// Purpose: format and first-channel offset registers over AXI4-Lite
// Assumes: one clock, synchronous active-low reset
// Notes: registers read back although the converter treats them write-only
`timescale 1ns/1ps
`include "output_format_offset_cfg.svh"
module output_format_offset_regs
  import output_format_offset_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic register_control,
  input wire logic output_swing_pin,
  input wire logic output_edge_pin,
  output format_out_t format_out,
  output offset_out_t offset_out,
  output logic format_written
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [3:0] word_index(input logic [5:0] addr);
    word_index = addr[5:2];
  endfunction : word_index

  function automatic logic is_mapped(input logic [3:0] idx);
    is_mapped = (idx == `CFG_IDX) || (idx == `OFS_IDX) || (idx == `STAT_IDX);
  endfunction : is_mapped

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = {strb[1] ? data[15:8] : old[15:8],
             strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge

  function automatic logic fixed_bits_wrong(input logic [15:0] word,
                                            input logic [15:0] mask,
                                            input logic [15:0] value);
    fixed_bits_wrong = (word & mask) != value;
  endfunction : fixed_bits_wrong

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] pin_raw;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic reg_ctrl;
  logic swing_pin_s;
  logic edge_pin_s;

  assign pin_raw = {register_control, output_swing_pin, output_edge_pin};

  // two flops per pin; only the second flop feeds logic
  for (genvar g = 0; g < 3; g++)
  begin : g_pin_sync
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        pin_meta[g] <= 1'b0;
        pin_sync[g] <= 1'b0;
      end
      else
      begin
        pin_meta[g] <= pin_raw[g];
        pin_sync[g] <= pin_meta[g];
      end
    end
  end

  assign reg_ctrl = pin_sync[2];
  assign swing_pin_s = pin_sync[1];
  assign edge_pin_s = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // write channel

  logic aw_held;
  logic w_held;
  logic [3:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [15:0] format_reg;
  logic [15:0] offset_reg;
  logic do_write;
  logic b_done;

  assign do_write = aw_held && w_held && !bvalid;
  assign b_done = bvalid && bready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      aw_held <= 1'b0;
      aw_idx <= 4'h0;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      aw_idx <= word_index(awaddr);
    end
    else
    begin
      if (do_write)
        aw_held <= 1'b0;
      if (b_done)
        awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready <= 1'b1;
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      wready <= 1'b0;
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end
    else
    begin
      if (do_write)
        w_held <= 1'b0;
      if (b_done)
        wready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write response

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp <= is_mapped(aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register store

  logic format_hit;
  logic offset_hit;

  assign format_hit = do_write && (aw_idx == `CFG_IDX);
  assign offset_hit = do_write && (aw_idx == `OFS_IDX);

  // stores words as written; fixed bits are the host's duty
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      format_reg <= `CFG_RESET;
    else if (format_hit)
      format_reg <= merge(format_reg, w_data, w_strb);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      offset_reg <= `OFS_RESET;
    else if (offset_hit)
      offset_reg <= merge(offset_reg, w_data, w_strb);
  end

  // flags every format rewrite, which can upset the data clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      format_written <= 1'b0;
    else
      format_written <= format_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output format decode

  logic is_ddr;
  logic edge_eff;
  logic swing_eff;
  output_mode_t next_mode;
  logic next_centred;
  logic [7:0] mag;
  logic [16:0] mag_uv;
  logic signed [16:0] next_offset_uv;

  assign is_ddr = !format_reg[`CFG_DDR_N_BIT];
  // register control overrides the pins
  assign edge_eff = reg_ctrl ? format_reg[`CFG_EDGE_BIT] : edge_pin_s;
  assign swing_eff = reg_ctrl ? format_reg[`CFG_SWING_BIT] : swing_pin_s;
  assign mag = offset_reg[`OFS_MAG_LSB +: 8];
  assign mag_uv = 17'({9'h0, mag} * `OFS_STEP_UV);
  assign next_offset_uv = offset_reg[`OFS_SIGN_BIT] ? -$signed(mag_uv)
                                                    : $signed(mag_uv);

  always_comb
  begin
    next_mode = MODE_SDR_FALLING;
    next_centred = 1'b0;
    if (is_ddr)
    begin
      if (format_reg[`CFG_EDGE_BIT])
      begin
        next_mode = MODE_DDR_NODEMUX;
        next_centred = 1'b0;
      end
      else
      begin
        next_mode = MODE_DDR_DEMUX;
        next_centred = format_reg[`CFG_PHASE_BIT];
      end
    end
    else if (edge_eff)
      next_mode = MODE_SDR_RISING;
    else
      next_mode = MODE_SDR_FALLING;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      format_out <= '{mode: MODE_DDR_DEMUX, swing_high: 1'b1,
                      clock_centred: 1'b0};
    end
    else
    begin
      case (next_mode)
        MODE_DDR_DEMUX, MODE_DDR_NODEMUX,
        MODE_SDR_RISING, MODE_SDR_FALLING: format_out.mode <= next_mode;
        default: format_out.mode <= MODE_DDR_DEMUX;
      endcase
      format_out.swing_high <= swing_eff;
      format_out.clock_centred <= next_centred;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offset output

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      offset_out <= '0;
    else
    begin
      offset_out.magnitude <= mag;
      offset_out.negative <= offset_reg[`OFS_SIGN_BIT];
      offset_out.offset_uv <= next_offset_uv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  logic [15:0] status_word;
  logic [3:0] ar_idx;
  logic ar_take;

  assign ar_idx = word_index(araddr);
  assign ar_take = arvalid && arready;
  assign status_word = {7'h0,
    fixed_bits_wrong(offset_reg, `OFS_FIXED_MASK, `OFS_FIXED_VAL),
    fixed_bits_wrong(format_reg, `CFG_FIXED_MASK, `CFG_FIXED_VAL),
    reg_ctrl, format_out.clock_centred, format_out.swing_high,
    format_out.mode};

  // read handshake: one read under way, arready back after the data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
    else if (ar_take)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // read data and response, captured with the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end
    else if (ar_take)
    begin
      rresp <= is_mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
      case (ar_idx)
        `CFG_IDX: rdata <= {16'h0, format_reg};
        `OFS_IDX: rdata <= {16'h0, offset_reg};
        `STAT_IDX: rdata <= {16'h0, status_word};
        default: rdata <= 32'h0;
      endcase
    end
  end

endmodule : output_format_offset_regs

/* bench/output_format_offset_props.sv */
// Purpose: properties of the format and offset bank
// Assumes: sees the top ports only
// Notes: bound at the foot
`timescale 1ns/1ps
module output_format_offset_chk
  import output_format_offset_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awready,
  input wire logic bvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic register_control,
  input wire logic output_swing_pin,
  input wire logic output_edge_pin,
  input wire format_out_t format_out,
  input wire offset_out_t offset_out,
  input wire logic format_written
);
  logic signed [16:0] mag_uv;
  assign mag_uv = {9'h000, offset_out.magnitude} * 17'h000b0;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_swing_pin_low;
    (!register_control && !output_swing_pin)[*4];
  endsequence
  sequence s_edge_pin_high;
    (!register_control && output_edge_pin)[*4];
  endsequence
  sequence s_write_ends;
    $rose(bvalid) ##1 !format_written;
  endsequence
  property p_one_hot; $onehot(format_out.mode); endproperty
  a_one_hot: assert property (p_one_hot) else $error("mode");
  property p_centre;
    format_out.clock_centred |-> format_out.mode == MODE_DDR_DEMUX;
  endproperty
  a_centre: assert property (p_centre) else $error("phase");
  property p_sign;
    offset_out.offset_uv == (offset_out.negative ? -mag_uv : mag_uv);
  endproperty
  a_sign: assert property (p_sign) else $error("sign");
  property p_range;
    offset_out.offset_uv <= 17'sh0afc8 && offset_out.offset_uv >= -17'sh0afc8;
  endproperty
  a_range: assert property (p_range) else $error("range");
  property p_zero;
    offset_out.magnitude == 8'h00 |-> offset_out.offset_uv == 17'h00000;
  endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_swing; s_swing_pin_low |=> !format_out.swing_high; endproperty
  a_swing: assert property (p_swing) else $error("swing pin");
  property p_edge;
    s_edge_pin_high |=> format_out.mode != MODE_SDR_FALLING;
  endproperty
  a_edge: assert property (p_edge) else $error("edge pin");
  property p_pulse; format_written |-> s_write_ends; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_wbusy; bvalid |-> !awready; endproperty
  a_wbusy: assert property (p_wbusy) else $error("awready");
  property p_rbusy; rvalid |-> !arready; endproperty
  a_rbusy: assert property (p_rbusy) else $error("arready");
endmodule : output_format_offset_chk
bind output_format_offset_regs output_format_offset_chk chk_inst (
  .aclk, .aresetn, .awready, .bvalid, .arready, .rvalid, .register_control,
  .output_swing_pin, .output_edge_pin, .format_out, .offset_out,
  .format_written
);

/* bench/host_model.sv */
// Purpose: host writing and reading the bank over AXI4-Lite
// Assumes: one write and one read at a time
// Notes: released payloads are inverted
`timescale 1ns/1ps
`include "output_format_offset_cfg.svh"
module host_model (
  input wire logic aclk,
  output logic [5:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [5:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  task automatic wr(input logic [5:0] a, input logic [15:0] d,
                    output logic [1:0] r);
    logic [15:0] v;
    logic aw_left;
    logic w_left;
    v = d;
    aw_left = 1'b1;
    w_left = 1'b1;
    if (a == {`CFG_IDX, 2'b00})
      v = (d & ~`CFG_FIXED_MASK) | `CFG_FIXED_VAL;
    if (a == {`OFS_IDX, 2'b00})
      v = d | `OFS_FIXED_VAL;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, v};
    wstrb <= 4'h3;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_left || w_left)
    begin
      @(posedge aclk);
      aw_left = aw_left && !awready;
      w_left = w_left && !wready;
      awvalid <= aw_left;
      wvalid <= w_left;
    end
    awaddr <= ~a;
    wdata <= ~wdata;
    do
      @(posedge aclk);
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge aclk);
    while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do
      @(posedge aclk);
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : host_model

/* bench/tb.sv */
// Purpose: self-checking bench for the format and offset bank
// Assumes: host_model drives the register bus
// Notes: checker is bound from its own file
`timescale 1ns/1ps
`include "output_format_offset_cfg.svh"
module tb
  import output_format_offset_pkg::*;
;
  localparam logic [5:0] FMT_A = {`CFG_IDX, 2'b00};
  localparam logic [5:0] OFS_A = {`OFS_IDX, 2'b00};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, format_written;
  logic register_control, output_swing_pin, output_edge_pin;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] k;
  logic [8:0] ofs [4] = '{9'h000, 9'h1fe, 9'h1ff, 9'h003};
  logic signed [16:0] u;
  output_mode_t m;
  format_out_t format_out;
  offset_out_t offset_out;
  int err_total = 0;
  int n_compared = 0;
  output_format_offset_regs output_format_offset_regs_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .register_control, .output_swing_pin,
    .output_edge_pin, .format_out, .offset_out, .format_written
  );
  host_model host_model_inst (
    .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready
  );
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle
  task automatic report_and_stop;
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial
  begin
    repeat (2000) @(posedge aclk);
    err_total++;
    report_and_stop();
  end
  initial
  begin
    {aresetn, output_edge_pin} = 2'b00;
    {register_control, output_swing_pin} = 2'b11;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    #1;
    check("reset out", {26'h0, MODE_DDR_DEMUX, 2'b10}, format_out);
    host_model_inst.rd(FMT_A, d, r);
    check("reset fmt", 32'h0000b2ff, d);
    host_model_inst.rd(OFS_A, d, r);
    check("reset ofs", 32'h0000007f, d);
    for (int i = 0; i < 8; i++)
    begin
      k = i[2:0];
      m = k[1] ? (k[0] ? MODE_SDR_RISING : MODE_SDR_FALLING)
               : (k[0] ? MODE_DDR_NODEMUX : MODE_DDR_DEMUX);
      host_model_inst.wr(FMT_A, {4'hb, ~k[2], k[1], k[2], k[0], 8'hff}, r);
      check("fmt resp", `RESP_OKAY, r);
      settle();
      check("mode", {m, k[2], k == 3'h0}, format_out);
    end
    for (int p = 1; p >= 0; p--)
    begin
      @(posedge aclk);
      {register_control, output_swing_pin, output_edge_pin} <= {2'b00, p[0]};
      repeat (5) @(posedge aclk);
      #1;
      m = p[0] ? MODE_SDR_RISING : MODE_SDR_FALLING;
      check("pin mode", {m, 2'b00}, format_out);
    end
    @(posedge aclk);
    register_control <= 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      host_model_inst.wr(OFS_A, {ofs[j], 7'h00}, r);
      settle();
      u = {9'h000, ofs[j][8:1]} * 17'h000b0;
      if (ofs[j][0])
        u = -u;
      check("ofs out", {ofs[j], u}, offset_out);
      host_model_inst.rd(OFS_A, d, r);
      check("ofs reg", {16'h0, ofs[j], 7'h7f}, d);
    end
    host_model_inst.wr(6'h3c, 16'h1234, r);
    check("bad wr", `RESP_SLVERR, r);
    host_model_inst.rd(6'h3c, d, r);
    check("bad rd", {d[31:2], `RESP_SLVERR} & 32'h3, {d[31:2], r} & 32'h3);
    check("bad data", 32'h0, d);
    host_model_inst.rd(FMT_A, d, r);
    check("fmt kept", 32'h0000b7ff, d);
    host_model_inst.rd({`STAT_IDX, 2'b00}, d, r);
    check("status", 32'h00000054, d);
    report_and_stop();
  end
endmodule : tb
